// >>> hdl/mrc_top.sv
// Purpose: Strap decode, setpoint code handling, transition flag and status pin
// Assumes: Straps and code pins arrive as synchronous digital levels
// Notes:   Analogue divider, ramp and comparators live outside this block
//
// Summary of operation
// - Floating phase strap: phases one, three only
// - Shorted strap six-bit, resistor eight-bit table
// - Eight-bit mode subtracts 19 mV offset
// - Eight-bit: strap sets soft-start, gain max 2
// - Six-bit: fixed soft-start, gain fixed 2
// - Code selects divider tap as setpoint
// - Variant pin picks eight-bit table, static
// - Eight-bit: open code pin reads one
// - Six-bit: open code pin reads zero
// - Six-bit: top pin flags change, 32-cycle tail
// - Eight-bit: status pin marks soft-start end
// - Six-bit: status pin is power good
// - Code changes accepted during operation
// - Six-bit reference has no offset
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module mrc_top
	import mrc_pkg::*;
#(
	parameter int SS_CNT_W        = 16,
	parameter int SS_FIXED_CYCLES = 2048,
	parameter int SS_UNIT_CYCLES  = 1024,
	parameter int STEP_CYCLES     = 4
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [AXI_ADDR_W-1:0] awaddr,
	input  wire logic [2:0]            awprot,
	input  wire logic                  awvalid,
	output var  logic                  awready_ff,
	input  wire logic [AXI_DATA_W-1:0] wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output var  logic                  wready_ff,
	output var  logic [1:0]            bresp_ff,
	output var  logic                  bvalid_ff,
	input  wire logic                  bready,
	input  wire logic [AXI_ADDR_W-1:0] araddr,
	input  wire logic [2:0]            arprot,
	input  wire logic                  arvalid,
	output var  logic                  arready_ff,
	output var  logic [AXI_DATA_W-1:0] rdata_ff,
	output var  logic [1:0]            rresp_ff,
	output var  logic                  rvalid_ff,
	input  wire logic                  rready,
	input  wire logic                  phase_select_floating,
	input  wire logic                  softstart_gain_table_strap_shorted,
	input  wire logic [3:0]            strap_resistor_code,
	input  wire logic                  table_variant_select_open,
	input  wire logic [7:0]            setpoint_code_driven,
	input  wire logic [7:0]            setpoint_code_level,
	input  wire logic                  output_enable,
	input  wire logic                  output_in_range,
	output var  logic [2:0]            phase_enable_ff,
	output var  logic                  table_eight_bit_ff,
	output var  logic                  table_variant_new_ff,
	output var  logic [7:0]            ref_tap_ff,
	output var  logic [7:0]            ref_offset_mv_ff,
	output var  logic [2:0]            boost_gain_halves_ff,
	output var  logic                  code_seven_out_ff,
	output var  logic                  code_seven_oe_ff,
	output var  logic                  status_pin_oe_ff,
	output var  logic                  irq_ff
);

	mrc_cfg_t                cfg_ff, nxt_cfg;
	logic                    latched_ff, nxt_latched;
	mrc_state_t              state_ff, nxt_state;
	logic [SS_CNT_W-1:0]     ss_cnt_ff, nxt_ss_cnt, ss_len;
	logic [7:0]              target_ff, nxt_target, code_now, nxt_tap;
	logic [7:0]              nxt_ref_offset;
	logic [2:0]              nxt_phase;
	logic [15:0]             step_cnt_ff, nxt_step_cnt;
	logic [5:0]              hold_ff, nxt_hold;
	logic                    moving_ff, nxt_moving, in_range_ff;
	logic [EVT_W-1:0]        evt, status_ff, nxt_status, mask_ff, nxt_mask, stat_clr;
	logic [31:0]             ctrl_ff, nxt_ctrl, rd_word;
	logic                    aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
	logic [AXI_ADDR_W-1:0]   wa_ff, nxt_wa;
	logic [AXI_DATA_W-1:0]   wd_ff, nxt_wd;
	logic [3:0]              ws_ff, nxt_ws;
	logic                    nxt_bvalid, nxt_rvalid, rd_hit;
	logic [1:0]              nxt_bresp, nxt_rresp;
	logic [AXI_DATA_W-1:0]   nxt_rdata;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////////////
	// Code pins: undriven pins fall to the pull of the active table
	genvar gi;
	for (gi = 0; gi < 8; gi++) begin : g_code
		if (gi < 6) begin : g_low
			assign code_now[gi] = setpoint_code_driven[gi] ? setpoint_code_level[gi]
			                      : cfg_ff.mode8;
		end else begin : g_high
			// Top pins are unused inputs in six-bit mode; the top one becomes the flag
			assign code_now[gi] = cfg_ff.mode8 & (setpoint_code_driven[gi] ?
			                      setpoint_code_level[gi] : 1'b1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strap capture, once after reset release
	always_comb begin
		nxt_cfg     = cfg_ff;
		nxt_latched = 1'b1;
		if (!latched_ff) begin
			nxt_cfg.three_phase = !phase_select_floating;
			nxt_cfg.mode8       = !softstart_gain_table_strap_shorted;
			nxt_cfg.variant_new = !softstart_gain_table_strap_shorted &
			                      table_variant_select_open;
			nxt_cfg.ss_sel      = softstart_gain_table_strap_shorted ? 2'h0
			                      : strap_resistor_code[3:2];
			nxt_cfg.gain_halves = softstart_gain_table_strap_shorted ? GAIN_MAX_HALVES
			                      : 3'({1'b0, strap_resistor_code[1:0]} + 3'h1);
		end
		nxt_phase      = cfg_ff.three_phase ? PHASES_THREE : PHASES_TWO;
		nxt_ref_offset = cfg_ff.mode8 ? OFFSET8_MV : OFFSET6_MV;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff               <= '0;
			latched_ff           <= 1'b0;
			phase_enable_ff      <= PHASES_TWO;
			ref_offset_mv_ff     <= OFFSET6_MV;
			table_eight_bit_ff   <= 1'b0;
			table_variant_new_ff <= 1'b0;
			boost_gain_halves_ff <= GAIN_MAX_HALVES;
		end else begin
			cfg_ff               <= nxt_cfg;
			latched_ff           <= nxt_latched;
			phase_enable_ff      <= nxt_phase;
			ref_offset_mv_ff     <= nxt_ref_offset;
			table_eight_bit_ff   <= cfg_ff.mode8;
			table_variant_new_ff <= cfg_ff.variant_new;
			boost_gain_halves_ff <= cfg_ff.gain_halves;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start-up sequence, setpoint tracking and transition flag
	always_comb begin
		ss_len = cfg_ff.mode8 ? SS_CNT_W'(SS_UNIT_CYCLES * (int'(cfg_ff.ss_sel) + 1))
		         : SS_CNT_W'(SS_FIXED_CYCLES);
		nxt_state    = state_ff;
		nxt_ss_cnt   = ss_cnt_ff;
		nxt_target   = ctrl_ff[CTRL_OVR_EN_BIT] ? ctrl_ff[CTRL_OVR_LSB +: 8] : code_now;
		nxt_tap      = ref_tap_ff;
		nxt_step_cnt = step_cnt_ff;
		nxt_hold     = (hold_ff != 6'h00) ? 6'(hold_ff - 6'h01) : hold_ff;
		nxt_moving   = moving_ff;
		evt          = '0;
		case (state_ff)
			ST_OFF: begin
				nxt_tap = target_ff;
				if (latched_ff && output_enable) begin
					nxt_state  = ST_SOFTSTART;
					nxt_ss_cnt = ss_len;
				end
			end
			ST_SOFTSTART: begin
				nxt_tap = target_ff;
				if (ss_cnt_ff <= SS_CNT_W'(1)) begin
					nxt_state           = ST_RUN;
					evt[EVT_SS_DONE]    = 1'b1;
				end else begin
					nxt_ss_cnt = SS_CNT_W'(ss_cnt_ff - SS_CNT_W'(1));
				end
			end
			ST_RUN: begin
				// Changes ramp one tap per step rather than jumping the reference
				if (ref_tap_ff != target_ff) begin
					if (!moving_ff) begin
						evt[EVT_TRANS_START] = 1'b1;
						nxt_moving           = 1'b1;
						nxt_step_cnt         = 16'(STEP_CYCLES - 1);
					end else if (step_cnt_ff != 16'h0000) begin
						nxt_step_cnt = 16'(step_cnt_ff - 16'h0001);
					end else begin
						nxt_tap      = (ref_tap_ff < target_ff) ? 8'(ref_tap_ff + 8'h01)
						               : 8'(ref_tap_ff - 8'h01);
						nxt_step_cnt = 16'(STEP_CYCLES - 1);
					end
				end else if (moving_ff) begin
					nxt_moving         = 1'b0;
					nxt_hold           = 6'(FLAG_HOLD_CYCLES);
					evt[EVT_TRANS_END] = 1'b1;
				end
				if (in_range_ff && !output_in_range) begin
					evt[EVT_RANGE_LOST] = 1'b1;
				end
			end
			default: begin
				nxt_state = ST_OFF;
			end
		endcase
		if (!output_enable) begin
			nxt_state  = ST_OFF;
			nxt_moving = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff          <= ST_OFF;
			ss_cnt_ff         <= '0;
			target_ff         <= 8'h00;
			ref_tap_ff        <= 8'h00;
			step_cnt_ff       <= 16'h0000;
			hold_ff           <= 6'h00;
			moving_ff         <= 1'b0;
			in_range_ff       <= 1'b0;
			code_seven_out_ff <= 1'b0;
			code_seven_oe_ff  <= 1'b0;
			status_pin_oe_ff  <= 1'b1;
		end else begin
			state_ff          <= nxt_state;
			ss_cnt_ff         <= nxt_ss_cnt;
			target_ff         <= nxt_target;
			ref_tap_ff        <= nxt_tap;
			step_cnt_ff       <= nxt_step_cnt;
			hold_ff           <= nxt_hold;
			moving_ff         <= nxt_moving;
			in_range_ff       <= output_in_range;
			code_seven_out_ff <= !cfg_ff.mode8 && (nxt_moving || nxt_hold != 6'h00);
			code_seven_oe_ff  <= latched_ff && !cfg_ff.mode8;
			// Pin held low until released; six-bit mode adds the window check
			status_pin_oe_ff  <= !(nxt_state == ST_RUN &&
			                     (cfg_ff.mode8 || output_in_range));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave; address and data taken in either order
	always_comb begin
		rd_hit = 1'b1;
		case (araddr)
			ADDR_CONFIG: rd_word = {20'h00000, 2'h0, cfg_ff.ss_sel, 1'b0, cfg_ff.gain_halves,
			                        1'b0, cfg_ff.variant_new, cfg_ff.mode8, cfg_ff.three_phase};
			ADDR_STATUS: rd_word = {28'h0000000, status_ff};
			ADDR_MASK:   rd_word = {28'h0000000, mask_ff};
			ADDR_CODE:   rd_word = {14'h0000, moving_ff, code_seven_out_ff, ref_tap_ff, target_ff};
			ADDR_CTRL:   rd_word = ctrl_ff;
			default: begin
				rd_word = 32'h0000_0000;
				rd_hit  = 1'b0;
			end
		endcase
		nxt_aw_got = aw_got_ff | (awvalid & awready_ff);
		nxt_w_got  = w_got_ff | (wvalid & wready_ff);
		nxt_wa     = (awvalid & awready_ff) ? awaddr : wa_ff;
		nxt_wd     = (wvalid & wready_ff) ? wdata : wd_ff;
		nxt_ws     = (wvalid & wready_ff) ? wstrb : ws_ff;
		nxt_bvalid = bvalid_ff & !bready;
		nxt_bresp  = bresp_ff;
		nxt_mask   = mask_ff;
		nxt_ctrl   = ctrl_ff;
		if (aw_got_ff && w_got_ff) begin
			nxt_aw_got = 1'b0;
			nxt_w_got  = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = RESP_OKAY;
			if (wa_ff == ADDR_MASK && ws_ff[0]) begin
				nxt_mask = wd_ff[EVT_W-1:0];
			end else if (wa_ff == ADDR_CTRL) begin
				for (int b = 0; b < 4; b++) begin
					if (ws_ff[b]) begin
						nxt_ctrl[8*b +: 8] = wd_ff[8*b +: 8];
					end
				end
			end else if (wa_ff != ADDR_CONFIG && wa_ff != ADDR_STATUS &&
			             wa_ff != ADDR_CODE && wa_ff != ADDR_MASK) begin
				nxt_bresp = RESP_SLVERR;
			end
		end
		nxt_rvalid = rvalid_ff & !rready;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		stat_clr   = '0;
		if (arvalid && arready_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = rd_word;
			nxt_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
			stat_clr   = (araddr == ADDR_STATUS) ? status_ff : '0;
		end
		// New events win over a clearing read in the same cycle
		nxt_status = (status_ff & ~stat_clr) | evt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			wa_ff      <= '0;
			wd_ff      <= '0;
			ws_ff      <= 4'h0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= RESP_OKAY;
			mask_ff    <= MASK_RESET;
			ctrl_ff    <= CTRL_RESET;
			status_ff  <= '0;
			irq_ff     <= 1'b0;
		end else begin
			aw_got_ff  <= nxt_aw_got;
			w_got_ff   <= nxt_w_got;
			wa_ff      <= nxt_wa;
			wd_ff      <= nxt_wd;
			ws_ff      <= nxt_ws;
			awready_ff <= !nxt_aw_got && !nxt_bvalid;
			wready_ff  <= !nxt_w_got && !nxt_bvalid;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			arready_ff <= !nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rresp;
			mask_ff    <= nxt_mask;
			ctrl_ff    <= nxt_ctrl;
			status_ff  <= nxt_status;
			irq_ff     <= |(nxt_status & nxt_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_flag_high8;
		code_seven_out_ff[*8];
	endsequence
	sequence s_flag_tail;
		s_flag_high8 ##24 code_seven_out_ff ##1 (code_seven_out_ff == moving_ff);
	endsequence

	a_phase_map: assert property (latched_ff && $past(latched_ff) |->
		phase_enable_ff == (cfg_ff.three_phase ? PHASES_THREE : PHASES_TWO))
		else $error("phase enable does not match latched strap");
	a_straps_frozen: assert property ($past(latched_ff) |-> $stable(cfg_ff))
		else $error("strap configuration changed after capture");
	a_offset_mode: assert property ($past(latched_ff, 2) |->
		ref_offset_mv_ff == (table_eight_bit_ff ? OFFSET8_MV : OFFSET6_MV))
		else $error("reference offset wrong for table mode");
	a_gain_limit: assert property ($past(latched_ff, 2) |-> boost_gain_halves_ff <= GAIN_MAX_HALVES
		&& (table_eight_bit_ff || boost_gain_halves_ff == GAIN_MAX_HALVES))
		else $error("boost gain out of range");
	a_flag_tail: assert property ($fell(moving_ff) && !cfg_ff.mode8 && output_enable |->
		s_flag_tail)
		else $error("transition flag tail is not 32 cycles");
	a_status_release: assert property ($fell(status_pin_oe_ff) |->
		state_ff == ST_RUN && (cfg_ff.mode8 || $past(output_in_range)))
		else $error("status pin released early");
	a_open_pull_one: assert property (latched_ff && cfg_ff.mode8 && !ctrl_ff[CTRL_OVR_EN_BIT]
		&& !setpoint_code_driven[0] |=> target_ff[0])
		else $error("open code pin not read as one");
	a_open_pull_zero: assert property (latched_ff && !cfg_ff.mode8 && !ctrl_ff[CTRL_OVR_EN_BIT]
		&& !setpoint_code_driven[0] |=> !target_ff[0])
		else $error("open code pin not read as zero");
	a_tap_tracks: assert property (state_ff == ST_RUN && ref_tap_ff != target_ff && output_enable
		&& $stable(target_ff) |-> ##[1:8] !$stable(ref_tap_ff) || !output_enable)
		else $error("setpoint tap did not move toward new code");

endmodule : mrc_top
`default_nettype wire

// >>> hdl/mrc_pkg.sv
// Purpose: Shared constants and types for the regulator configuration decoder
// Assumes: 200 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   Register offsets are byte addresses of aligned words
package mrc_pkg;

	localparam int          CLK_PERIOD_NS    = 5;
	localparam int          AXI_ADDR_W       = 8;
	localparam int          AXI_DATA_W       = 32;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0]  ADDR_CONFIG      = 8'h00;
	localparam logic [7:0]  ADDR_STATUS      = 8'h04;
	localparam logic [7:0]  ADDR_MASK        = 8'h08;
	localparam logic [7:0]  ADDR_CODE        = 8'h0C;
	localparam logic [7:0]  ADDR_CTRL        = 8'h10;

	// Config readback field positions
	localparam int          CFG_THREE_PH     = 0;
	localparam int          CFG_MODE8        = 1;
	localparam int          CFG_VARIANT_NEW  = 2;
	localparam int          CFG_GAIN_LSB     = 4;
	localparam int          CFG_SS_LSB       = 8;

	// Status and mask bit positions
	localparam int          EVT_W            = 4;
	localparam int          EVT_TRANS_START  = 0;
	localparam int          EVT_TRANS_END    = 1;
	localparam int          EVT_SS_DONE      = 2;
	localparam int          EVT_RANGE_LOST   = 3;

	// Code register and control register fields
	localparam int          CODE_TAP_LSB     = 8;
	localparam int          CODE_FLAG_BIT    = 16;
	localparam int          CODE_MOVING_BIT  = 17;
	localparam int          CTRL_OVR_EN_BIT  = 0;
	localparam int          CTRL_OVR_LSB     = 8;
	localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
	localparam logic [3:0]  MASK_RESET       = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration encodings
	localparam logic [2:0]  PHASES_TWO       = 3'h5;
	localparam logic [2:0]  PHASES_THREE     = 3'h7;
	localparam logic [2:0]  GAIN_MAX_HALVES  = 3'h4;
	localparam logic [7:0]  OFFSET8_MV       = 8'hED;
	localparam logic [7:0]  OFFSET6_MV       = 8'h00;
	localparam int          FLAG_HOLD_CYCLES = 32;

	typedef struct packed {
		logic       three_phase;
		logic       mode8;
		logic       variant_new;
		logic [2:0] gain_halves;
		logic [1:0] ss_sel;
	} mrc_cfg_t;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_SOFTSTART,
		ST_RUN
	} mrc_state_t;

endpackage : mrc_pkg

// >>> verif/mrc_proc_model.sv
// Purpose: Processor model driving the setpoint code pins
// Assumes: Testbench updates its wishes just after a clock edge
// Notes:   Open pins carry a toggling level, so a stale value cannot pass
`timescale 1ns/1ps
`default_nettype none

module mrc_proc_model (
	input  wire logic       aclk,
	input  wire logic [7:0] want_code,
	input  wire logic [7:0] want_drive,
	output var  logic [7:0] setpoint_code_driven,
	output var  logic [7:0] setpoint_code_level
);
	logic tgl = 1'b0;

	always @(posedge aclk) begin
		tgl <= ~tgl;
	end

	// Code held static between changes; code six grounded in six-bit use
	assign setpoint_code_driven = want_drive;
	assign setpoint_code_level  = (want_code & want_drive) | (~want_drive & {8{tgl}});
endmodule : mrc_proc_model
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the regulator configuration decoder
// Assumes: Short soft-start counts, AXI4-Lite master tasks
// Notes:   Straps are set during reset, as a board would before start-up
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import mrc_pkg::*;

	logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [AXI_ADDR_W-1:0] awaddr, araddr;
	logic [AXI_DATA_W-1:0] wdata, rdata_ff, rd;
	logic [3:0]            wstrb, strap_res;
	logic [1:0]            bresp_ff, rresp_ff, rsp;
	logic                  awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic                  ph_float, shorted, var_open, out_en, in_range, irq_ff;
	logic [7:0]            want_code, want_drive, code_drv, code_lvl;
	logic [2:0]            phase_enable_ff, boost_gain_halves_ff;
	logic [7:0]            ref_tap_ff, ref_offset_mv_ff;
	logic                  table_eight_bit_ff, table_variant_new_ff;
	logic                  code_seven_out_ff, code_seven_oe_ff, status_pin_oe_ff;
	int                    n_fail, samples_checked;
	// Short soft-start counts keep the run brief; expected lengths derive from these
	localparam int         SS_FIXED_TB = 8;
	localparam int         SS_UNIT_TB  = 4;

	always #(CLK_PERIOD_NS / 2.0) aclk = ~aclk;

	mrc_top #(.SS_FIXED_CYCLES(SS_FIXED_TB), .SS_UNIT_CYCLES(SS_UNIT_TB),
		.STEP_CYCLES(4)) u_mrc_top (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready_ff(awready_ff), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready_ff(wready_ff), .bresp_ff(bresp_ff),
		.bvalid_ff(bvalid_ff), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready_ff(arready_ff), .rdata_ff(rdata_ff),
		.rresp_ff(rresp_ff), .rvalid_ff(rvalid_ff), .rready(rready),
		.phase_select_floating(ph_float), .softstart_gain_table_strap_shorted(shorted),
		.strap_resistor_code(strap_res), .table_variant_select_open(var_open),
		.setpoint_code_driven(code_drv), .setpoint_code_level(code_lvl),
		.output_enable(out_en), .output_in_range(in_range),
		.phase_enable_ff(phase_enable_ff), .table_eight_bit_ff(table_eight_bit_ff),
		.table_variant_new_ff(table_variant_new_ff), .ref_tap_ff(ref_tap_ff),
		.ref_offset_mv_ff(ref_offset_mv_ff), .boost_gain_halves_ff(boost_gain_halves_ff),
		.code_seven_out_ff(code_seven_out_ff), .code_seven_oe_ff(code_seven_oe_ff),
		.status_pin_oe_ff(status_pin_oe_ff), .irq_ff(irq_ff)
	);

	mrc_proc_model u_mrc_proc_model (
		.aclk(aclk), .want_code(want_code), .want_drive(want_drive),
		.setpoint_code_driven(code_drv), .setpoint_code_level(code_lvl)
	);

	////////////////////////////////////////////////////////////////
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s response expected %h seen %h", nm, e, g);
		end
	endtask : chk_resp

	task automatic timeout_fail(input string nm);
		n_fail++;
		$display("[ERR] %s wait expected done seen timeout", nm);
		results();
	endtask : timeout_fail

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	// Master holds each channel until its own ready; no fixed latency assumed
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready_ff) awvalid <= 1'b0;
			if (wvalid && wready_ff) wvalid <= 1'b0;
		end while (bvalid_ff !== 1'b1 && n < 100);
		if (n >= 100) timeout_fail("write");
		r = bresp_ff;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready_ff) arvalid <= 1'b0;
		end while (rvalid_ff !== 1'b1 && n < 100);
		if (n >= 100) timeout_fail("read");
		d = rdata_ff;
		r = rresp_ff;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic do_reset(input logic pf, input logic sh, input logic vo, input logic [3:0] sr);
		@(posedge aclk);
		aresetn   <= 1'b0;
		out_en    <= 1'b0;
		ph_float  <= pf;
		shorted   <= sh;
		var_open  <= vo;
		strap_res <= sr;
		cyc(20);
		aresetn <= 1'b1;
		cyc(3);
	endtask : do_reset

	task automatic wait_release(output int n);
		n = 0;
		while (status_pin_oe_ff !== 1'b0 && n < 50) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 50) timeout_fail("status release");
	endtask : wait_release

	////////////////////////////////////////////////////////////////
	initial begin
		int  n;
		int  g;
		logic seen;
		aclk = 1'b0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, in_range} <= '0;
		{awaddr, araddr, wdata} <= '0;
		wstrb      <= 4'hF;
		want_code  <= 8'h00;
		want_drive <= 8'h40;
		n_fail = 0;
		samples_checked = 0;
		// Six-bit table, three phases
		do_reset(1'b0, 1'b1, 1'b0, 4'h0);
		chk("phases", 32'(PHASES_THREE), 32'(phase_enable_ff));
		chk("mode8", 32'h0, 32'(table_eight_bit_ff));
		chk("offset", 32'(OFFSET6_MV), 32'(ref_offset_mv_ff));
		chk("gain", 32'(GAIN_MAX_HALVES), 32'(boost_gain_halves_ff));
		chk("flag_oe", 32'h1, 32'(code_seven_oe_ff));
		axi_rd(ADDR_CONFIG, rd, rsp);
		chk("config", 32'h0000_0041, rd & 32'h0000_007F);
		axi_rd(ADDR_CODE, rd, rsp);
		chk("target_open", 32'h0, rd & 32'h0000_00FF);
		// Late strap moves must not reach the outputs
		ph_float <= 1'b1;
		shorted  <= 1'b0;
		cyc(4);
		chk("phases_late", 32'(PHASES_THREE), 32'(phase_enable_ff));
		chk("mode8_late", 32'h0, 32'(table_eight_bit_ff));
		// Register bus
		axi_rd(ADDR_MASK, rd, rsp);
		chk("mask_reset", 32'(MASK_RESET), rd & 32'h0000_000F);
		axi_wr(ADDR_MASK, 32'h1 << EVT_SS_DONE, rsp);
		chk_resp("mask_wr", RESP_OKAY, rsp);
		axi_rd(ADDR_MASK, rd, rsp);
		chk("mask", 32'h1 << EVT_SS_DONE, rd & 32'h0000_000F);
		axi_rd(8'h20, rd, rsp);
		chk_resp("unmapped_rd", RESP_SLVERR, rsp);
		axi_wr(8'h20, 32'h0000_FFFF, rsp);
		chk_resp("unmapped_wr", RESP_SLVERR, rsp);
		axi_wr(ADDR_CONFIG, 32'h0, rsp);
		axi_rd(ADDR_CONFIG, rd, rsp);
		chk("config_ro", 32'h0000_0041, rd & 32'h0000_007F);
		axi_wr(ADDR_CTRL, 32'h0000_2201, rsp);
		axi_rd(ADDR_CODE, rd, rsp);
		chk("target_ovr", 32'h22, rd & 32'h0000_00FF);
		axi_wr(ADDR_CTRL, CTRL_RESET, rsp);
		axi_rd(ADDR_CTRL, rd, rsp);
		chk("ctrl", CTRL_RESET, rd);
		// Processor applies a code; before start-up the tap follows it
		want_drive <= 8'h7F;
		want_code  <= 8'h15;
		cyc(4);
		chk("tap", 32'h15, 32'(ref_tap_ff));
		// Soft-start, then power good only while in range
		in_range <= 1'b1;
		out_en   <= 1'b1;
		cyc(4);
		chk("pg_early", 32'h1, 32'(status_pin_oe_ff));
		wait_release(n);
		// Release is seen two edges after the count ends; four edges already waited
		chk("ss_len6", 32'(SS_FIXED_TB + 2 - 4), 32'(n));
		cyc(2);
		chk("irq_set", 32'h1, 32'(irq_ff));
		axi_rd(ADDR_STATUS, rd, rsp);
		chk("ss_done", 32'h1, (rd >> EVT_SS_DONE) & 32'h1);
		cyc(2);
		chk("irq_clr", 32'h0, 32'(irq_ff));
		in_range <= 1'b0;
		cyc(3);
		chk("pg_lost", 32'h1, 32'(status_pin_oe_ff));
		chk("irq_masked", 32'h0, 32'(irq_ff));
		in_range <= 1'b1;
		cyc(3);
		chk("pg_back", 32'h0, 32'(status_pin_oe_ff));
		// Setpoint change in run: flag during move and a 32-cycle tail
		want_code <= 8'h18;
		n = 0;
		seen = 1'b0;
		while (ref_tap_ff !== 8'h18 && n < 200) begin
			@(posedge aclk);
			n++;
			seen |= (code_seven_out_ff === 1'b1);
		end
		if (n >= 200) timeout_fail("tap move");
		chk("flag_seen", 32'h1, 32'(seen));
		cyc(28);
		chk("flag_tail", 32'h1, 32'(code_seven_out_ff));
		cyc(12);
		chk("flag_end", 32'h0, 32'(code_seven_out_ff));
		axi_rd(ADDR_STATUS, rd, rsp);
		chk("trans_evt", 32'h3, rd & 32'h3);
		chk("range_evt", 32'h1, (rd >> EVT_RANGE_LOST) & 32'h1);
		// Eight-bit table: every gain code, both table variants
		want_drive <= 8'h00;
		for (g = 0; g < 4; g++) begin
			do_reset(1'b1, 1'b0, g[0], {2'h1, g[1:0]});
			chk("gain8", 32'(g + 1), 32'(boost_gain_halves_ff));
			chk("variant", 32'(g[0]), 32'(table_variant_new_ff));
		end
		chk("phases8", 32'(PHASES_TWO), 32'(phase_enable_ff));
		chk("mode8_on", 32'h1, 32'(table_eight_bit_ff));
		chk("offset8", 32'(OFFSET8_MV), 32'(ref_offset_mv_ff));
		chk("flag_oe8", 32'h0, 32'(code_seven_oe_ff));
		axi_rd(ADDR_CONFIG, rd, rsp);
		chk("config8", 32'h0000_0146, rd & 32'h0000_037F);
		axi_rd(ADDR_CODE, rd, rsp);
		chk("target8_open", 32'hFF, rd & 32'h0000_00FF);
		want_drive <= 8'hFF;
		want_code  <= 8'h3C;
		cyc(4);
		chk("tap8", 32'h3C, 32'(ref_tap_ff));
		// Soft-start end is flagged even with the output out of range
		in_range <= 1'b0;
		out_en   <= 1'b1;
		cyc(5);
		chk("softstart_done_output_early", 32'h1, 32'(status_pin_oe_ff));
		wait_release(n);
		// Soft-start select 1 gives two units; five edges already waited
		chk("ss_len8", 32'(SS_UNIT_TB * 2 + 2 - 5), 32'(n));
		results();
	end
endmodule : tb_top
`default_nettype wire
